// ==== include/bms_regs.svh ====
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit avalon-mm slave with byte addresses
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH
`define BMS_ADDR_CONFIG     6'h00
`define BMS_ADDR_CONTROL    6'h04
`define BMS_ADDR_STATUS     6'h08
`define BMS_ADDR_RAW_BRIDGE 6'h0C
`define BMS_ADDR_RAW_TEMP   6'h10
`define BMS_ADDR_RAW_OFFSET 6'h14
`define BMS_ADDR_DECODED    6'h18
`define BMS_CONFIG_RESET    13'h0000
`define BMS_CTRL_START      0
`define BMS_CTRL_MODE       1
`define BMS_CTRL_CMD_LO     2
`define BMS_CTRL_CMD_HI     3
`define BMS_STAT_DONE       0
`define BMS_STAT_BUSY       1
`define BMS_STAT_ASLEEP     2
`define BMS_WAKE_TIME_US    2000
`define BMS_CLK_MHZ         200
`define BMS_WAKE_CYCLES     (`BMS_WAKE_TIME_US * `BMS_CLK_MHZ)
`define BMS_AZ_CYCLES       16'h0040
`endif

// ==== include/bms_pkg.sv ====
// types shared by the measurement sequencer and its bench
// no assumptions beyond a single clock domain
package bms_pkg;
    typedef struct packed {
        logic [2:0] converter_shift_sel;
        logic [1:0] fine_sel;
        logic [1:0] coarse_sel;
        logic       polarity;
        logic [2:0] second_stage_gain_sel;
        logic [1:0] first_stage_gain_sel;
    } bms_config_type;

    typedef enum logic [1:0] {
        BMS_SRC_BRIDGE = 2'h0,
        BMS_SRC_TEMP   = 2'h1,
        BMS_SRC_SHORT  = 2'h2
    } bms_source_type;

    typedef enum logic [1:0] {
        BMS_CMD_FULL   = 2'h0,
        BMS_CMD_BRIDGE = 2'h1,
        BMS_CMD_TEMP   = 2'h2,
        BMS_CMD_OFFSET = 2'h3
    } bms_cmd_type;

    typedef enum logic [2:0] {
        BMS_ST_INIT  = 3'h0,
        BMS_ST_SLEEP = 3'h1,
        BMS_ST_WAKE  = 3'h2,
        BMS_ST_IDLE  = 3'h3,
        BMS_ST_AZ    = 3'h4,
        BMS_ST_CONV  = 3'h5,
        BMS_ST_WAIT  = 3'h6,
        BMS_ST_CORR  = 3'h7
    } bms_state_type;

    typedef struct packed {
        logic           awake;
        bms_source_type source;
        logic           auto_zero;
        logic           conv_start;
        logic           chopper_invert;
    } bms_frontend_type;
endpackage

// ==== rtl/bms_sequencer.sv ====
// bridge measurement sequencer: config decode, measurement sequencing,
// sleep/wake cycle and an avalon-mm register slave
// assumes the front end answers each conv_start with one conv_done pulse
// What this block does
// - automatic mode and command mode only
// - automatic: wake, measure once, sleep again
// - reset drives all logic to defined state
// - input select: bridge, temperature or short
// - full request runs bridge, temperature, offset
// - auto-zero before bridge and temperature
// - raw results handed to correction processor
// - low five config bits hold gains
// - first stage gain 12/20/30/40
// - second stage gain 1.1 to 1.8
// - polarity bit inverts chopper clock
// - resolution is coarse plus fine minus one
// - coarse samples two-to-coarse, time adds fine
// - three-bit converter shift selection
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "bms_regs.svh"
module bms_sequencer
    import bms_pkg::*;
#(
    parameter int unsigned WAKE_CYCLES = `BMS_WAKE_CYCLES
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [5:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    input  wire logic [15:0]      nvm_config,
    output bms_frontend_type      frontend,
    input  wire logic             conv_done,
    input  wire logic [17:0]      conv_result,
    output bms_config_type        active_config,
    output logic      [5:0]       first_stage_gain,
    output logic      [4:0]       second_stage_gain_x10,
    output logic      [4:0]       coarse_bits,
    output logic      [2:0]       fine_bits,
    output logic      [4:0]       resolution,
    output logic      [16:0]      coarse_samples,
    output logic      [17:0]      conv_cycles,
    output logic      [17:0]      raw_bridge,
    output logic      [17:0]      raw_temp,
    output logic      [17:0]      raw_offset,
    output logic                  corr_start
);
    // decode used by outputs and the register read path
    function automatic logic [4:0] coarse_of(input logic [1:0] s);
        coarse_of = 5'h0A + {2'h0, s, 1'b0};
    endfunction

    function automatic logic [2:0] fine_of(input logic [1:0] s);
        case (s)
            2'h0:    fine_of = 3'h0;
            2'h1:    fine_of = 3'h3;
            2'h2:    fine_of = 3'h5;
            default: fine_of = 3'h7;
        endcase
    endfunction

    bms_state_type  state;
    bms_state_type  next_state;
    logic [1:0]     step;
    logic [1:0]     next_step;
    logic           auto_mode;
    logic [1:0]     cmd;
    logic           start_pulse;
    logic           done_flag;
    logic [31:0]    timer;
    logic           ack;
    logic           wr_en;
    logic           rd_en;
    logic           in_flight;
    bms_source_type cur_src;

    // a request is answered one cycle after it appears
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_en = avs_write & ack;
    assign rd_en = avs_read & ~ack;
    // config may only change while no measurement is in flight; the edge
    // that starts a measurement counts as in flight for config writes
    assign in_flight = (state == BMS_ST_AZ) || (state == BMS_ST_CONV) ||
                       (state == BMS_ST_WAIT) || (state == BMS_ST_WAKE);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end

    // reset constant only; the strap word is taken in the init state
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            active_config <= bms_config_type'(`BMS_CONFIG_RESET);
        end else if (state == BMS_ST_INIT) begin
            active_config <= bms_config_type'(nvm_config[12:0]);
        end else if (wr_en && avs_address == `BMS_ADDR_CONFIG &&
                     !in_flight && next_state != BMS_ST_AZ &&
                     next_state != BMS_ST_CONV) begin
            active_config <= bms_config_type'(avs_writedata[12:0]);
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            auto_mode   <= 1'b1;
            cmd         <= 2'h0;
            start_pulse <= 1'b0;
        end else begin
            start_pulse <= 1'b0;
            if (wr_en && avs_address == `BMS_ADDR_CONTROL) begin
                auto_mode   <= ~avs_writedata[`BMS_CTRL_MODE];
                cmd         <= avs_writedata[`BMS_CTRL_CMD_HI:`BMS_CTRL_CMD_LO];
                start_pulse <= avs_writedata[`BMS_CTRL_START];
            end
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            done_flag <= 1'b0;
        end else if (state == BMS_ST_CORR) begin
            done_flag <= 1'b1;
        end else if (wr_en && avs_address == `BMS_ADDR_STATUS &&
                     avs_writedata[`BMS_STAT_DONE]) begin
            done_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (avs_address)
                `BMS_ADDR_CONFIG:
                    avs_readdata <= {19'h00000, active_config};
                `BMS_ADDR_CONTROL:
                    avs_readdata <= {28'h0000000, cmd, ~auto_mode, 1'b0};
                `BMS_ADDR_STATUS:
                    avs_readdata <= {26'h0000000, state,
                                     state == BMS_ST_SLEEP,
                                     in_flight, done_flag};
                `BMS_ADDR_RAW_BRIDGE:
                    avs_readdata <= {14'h0000, raw_bridge};
                `BMS_ADDR_RAW_TEMP:
                    avs_readdata <= {14'h0000, raw_temp};
                `BMS_ADDR_RAW_OFFSET:
                    avs_readdata <= {14'h0000, raw_offset};
                `BMS_ADDR_DECODED:
                    avs_readdata <= {19'h00000, resolution, fine_bits,
                                     coarse_bits};
                default:
                    avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // decoded settings follow the latched config only
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            first_stage_gain      <= 6'h0C;
            second_stage_gain_x10 <= 5'h0B;
            coarse_bits           <= 5'h0A;
            fine_bits             <= 3'h0;
            resolution            <= 5'h09;
            coarse_samples        <= 17'h00400;
            conv_cycles           <= 18'h00401;
        end else begin
            case (active_config.first_stage_gain_sel)
                2'h0:    first_stage_gain <= 6'h0C;
                2'h1:    first_stage_gain <= 6'h14;
                2'h2:    first_stage_gain <= 6'h1E;
                default: first_stage_gain <= 6'h28;
            endcase
            second_stage_gain_x10 <=
                5'h0B + {2'h0, active_config.second_stage_gain_sel};
            coarse_bits <= coarse_of(active_config.coarse_sel);
            fine_bits   <= fine_of(active_config.fine_sel);
            resolution  <= coarse_of(active_config.coarse_sel) +
                           {2'h0, fine_of(active_config.fine_sel)} -
                           5'h01;
            coarse_samples <=
                17'h00001 << coarse_of(active_config.coarse_sel);
            conv_cycles <=
                (18'h00001 << coarse_of(active_config.coarse_sel)) +
                (18'h00001 << fine_of(active_config.fine_sel));
        end
    end

    // step: 0 bridge, 1 temperature, 2 offset; follows the step being
    // entered so a direct jump to the offset conversion shorts the input
    always_comb begin
        case (next_step)
            2'h0:    cur_src = BMS_SRC_BRIDGE;
            2'h1:    cur_src = BMS_SRC_TEMP;
            default: cur_src = BMS_SRC_SHORT;
        endcase
    end

    always_comb begin
        next_state = state;
        next_step  = step;
        case (state)
            BMS_ST_INIT:  next_state = BMS_ST_SLEEP;
            BMS_ST_SLEEP: begin
                if (start_pulse)
                    next_state = BMS_ST_WAKE;
            end
            BMS_ST_WAKE: begin
                if (timer >= WAKE_CYCLES - 1)
                    next_state = BMS_ST_IDLE;
            end
            BMS_ST_IDLE: begin
                if (start_pulse || auto_mode) begin
                    next_step  = (auto_mode || cmd == BMS_CMD_FULL) ?
                                 2'h0 : 2'(cmd - 2'h1);
                    next_state = (next_step == 2'h2) ?
                                 BMS_ST_CONV : BMS_ST_AZ;
                end
            end
            BMS_ST_AZ: begin
                if (timer >= 32'(`BMS_AZ_CYCLES) - 1)
                    next_state = BMS_ST_CONV;
            end
            BMS_ST_CONV:  next_state = BMS_ST_WAIT;
            BMS_ST_WAIT: begin
                if (conv_done) begin
                    if ((auto_mode || cmd == BMS_CMD_FULL) &&
                        step != 2'h2) begin
                        next_step  = step + 2'h1;
                        next_state = (next_step == 2'h2) ?
                                     BMS_ST_CONV : BMS_ST_AZ;
                    end else begin
                        next_state = BMS_ST_CORR;
                    end
                end
            end
            BMS_ST_CORR: begin
                next_state = auto_mode ? BMS_ST_SLEEP :
                             BMS_ST_IDLE;
            end
            default: next_state = BMS_ST_INIT;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= BMS_ST_INIT;
            step  <= 2'h0;
        end else begin
            state <= next_state;
            step  <= next_step;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            timer <= 32'h0000_0000;
        end else if (next_state != state) begin
            timer <= 32'h0000_0000;
        end else begin
            timer <= timer + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            raw_bridge <= 18'h00000;
            raw_temp   <= 18'h00000;
            raw_offset <= 18'h00000;
        end else if (state == BMS_ST_WAIT && conv_done) begin
            case (step)
                2'h0:    raw_bridge <= conv_result;
                2'h1:    raw_temp   <= conv_result;
                default: raw_offset <= conv_result;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            corr_start <= 1'b0;
            frontend   <= '0;
        end else begin
            corr_start <= (next_state == BMS_ST_CORR);
            frontend.awake <= (next_state != BMS_ST_SLEEP) &&
                              (next_state != BMS_ST_INIT);
            frontend.source     <= (next_state == BMS_ST_AZ) ?
                                   BMS_SRC_SHORT : cur_src;
            frontend.auto_zero  <= (next_state == BMS_ST_AZ);
            frontend.conv_start <= (next_state == BMS_ST_CONV);
            frontend.chopper_invert <= active_config.polarity;
        end
    end
endmodule

// ==== tb/bms_frontend_model.sv ====
// front end stand-in: answers each conversion start with one done pulse
// assumes the bench sets latency and result base between measurements
`timescale 1ns/1ps
module bms_frontend_model
    import bms_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire bms_frontend_type frontend,
    input  wire logic [7:0]       latency,
    input  wire logic [17:0]      base,
    output logic                  conv_done,
    output logic      [17:0]      conv_result
);
    logic [7:0]     count;
    logic           pending;
    bms_source_type src;

    // result is base plus source code so a stored value shows its step
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pending     <= 1'b0;
            count       <= 8'h00;
            src         <= BMS_SRC_BRIDGE;
            conv_done   <= 1'b0;
            conv_result <= 18'h00000;
        end else begin
            conv_done   <= 1'b0;
            // outside the done pulse the data inverts each cycle, so the last result returns every second cycle
            conv_result <= ~conv_result;
            if (frontend.conv_start) begin
                pending <= 1'b1;
                count   <= latency;
                src     <= frontend.source;
            end else if (pending && count == 8'h00) begin
                pending     <= 1'b0;
                conv_done   <= 1'b1;
                conv_result <= base + {16'h0000, src};
            end else if (pending) begin
                count <= count - 8'h01;
            end
        end
    end
endmodule

// ==== tb/bms_monitor.sv ====
// port-level checks of config decode and measurement sequencing
// assumes one clock domain with asynchronous active-high reset
`timescale 1ns/1ps
module bms_monitor
    import bms_pkg::*;
(
    input wire logic             core_clk,
    input wire logic             reset,
    input wire bms_frontend_type frontend,
    input wire bms_config_type   active_config,
    input wire logic [5:0]       first_stage_gain,
    input wire logic [4:0]       second_stage_gain_x10,
    input wire logic [4:0]       coarse_bits,
    input wire logic [2:0]       fine_bits,
    input wire logic [4:0]       resolution,
    input wire logic [16:0]      coarse_samples,
    input wire logic [17:0]      conv_cycles
);
    localparam logic [5:0] GAIN1[4] = '{6'h0C, 6'h14, 6'h1E, 6'h28};
    localparam logic [2:0] FINE[4] = '{3'h0, 3'h3, 3'h5, 3'h7};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_resolution_sum: assert property (
        resolution == coarse_bits + fine_bits - 5'h01)
        else $error("resolution differs from segment sum");
    a_coarse_samples: assert property (
        coarse_samples == 17'h00001 << coarse_bits)
        else $error("coarse sample count wrong");
    a_conv_cycles: assert property (
        conv_cycles == (18'h1 << coarse_bits) + (18'h1 << fine_bits))
        else $error("conversion cycle count wrong");
    a_first_gain: assert property (
        first_stage_gain == GAIN1[$past(active_config.first_stage_gain_sel)])
        else $error("first stage gain decode wrong");
    a_second_gain: assert property (
        second_stage_gain_x10 ==
            5'h0B + $past(active_config.second_stage_gain_sel))
        else $error("second stage gain decode wrong");
    a_segment_decode: assert property (
        coarse_bits == {2'h0, $past(active_config.coarse_sel), 1'b0} + 5'h0A
        && fine_bits == FINE[$past(active_config.fine_sel)])
        else $error("segmentation decode wrong");
    a_chopper_polarity: assert property (
        frontend.awake && $stable(active_config.polarity)
        |-> frontend.chopper_invert == active_config.polarity)
        else $error("chopper inversion does not follow polarity");
    a_config_hold: assert property (
        frontend.auto_zero || frontend.conv_start |-> $stable(active_config))
        else $error("config changed during a measurement");
    a_zero_shorted: assert property (
        frontend.auto_zero |-> frontend.source == BMS_SRC_SHORT)
        else $error("auto-zero without shorted input");
    a_zero_before: assert property (
        frontend.conv_start && frontend.source != BMS_SRC_SHORT
        |-> $past(frontend.auto_zero))
        else $error("measurement not preceded by auto-zero");
endmodule

bind bms_sequencer bms_monitor i_monitor (
    .core_clk(core_clk), .reset(reset), .frontend(frontend),
    .active_config(active_config), .first_stage_gain(first_stage_gain),
    .second_stage_gain_x10(second_stage_gain_x10),
    .coarse_bits(coarse_bits), .fine_bits(fine_bits),
    .resolution(resolution), .coarse_samples(coarse_samples),
    .conv_cycles(conv_cycles));

// ==== tb/bms_sequencer_bench.sv ====
// bench for the sequencer: avalon-mm master, front end model, read checks
// assumes a short wake count; expected reads queue up for the watcher
`timescale 1ns/1ps
`include "bms_regs.svh"
module bms_sequencer_bench;
    import bms_pkg::*;
    localparam int unsigned WAKE = 10;
    logic             core_clk = 1'b0;
    logic             reset = 1'b1;
    logic [5:0]       avs_address = 6'h00;
    logic             avs_read = 1'b0;
    logic             avs_write = 1'b0;
    logic [31:0]      avs_writedata = 32'h0;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    logic [15:0]      nvm_config = 16'h0;
    bms_frontend_type frontend;
    logic             conv_done;
    logic [17:0]      conv_result;
    logic             corr_start;
    logic [7:0]       latency = 8'h00;
    logic [17:0]      base = 18'h0;
    logic [31:0]      exp_q[$];
    logic [5:0]       adr_q[$];
    logic [17:0]      raw[3];
    int               miscompares = 0;
    int               checked = 0;

    always #2.5 core_clk = ~core_clk;

    bms_sequencer #(.WAKE_CYCLES(WAKE)) i_dut (
        .core_clk(core_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .nvm_config(nvm_config),
        .frontend(frontend), .conv_done(conv_done),
        .conv_result(conv_result), .active_config(),
        .first_stage_gain(), .second_stage_gain_x10(), .coarse_bits(),
        .fine_bits(), .resolution(), .coarse_samples(), .conv_cycles(),
        .raw_bridge(), .raw_temp(), .raw_offset(), .corr_start(corr_start));
    bms_frontend_model i_fe (.core_clk(core_clk), .reset(reset),
        .frontend(frontend), .latency(latency), .base(base),
        .conv_done(conv_done), .conv_result(conv_result));

    task automatic complete_run();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic fail_wait();
        miscompares++;
        $display("wrong value wait expected answer seen timeout");
        complete_run();
    endtask

    task automatic compare_read(input logic [5:0] a, input logic [31:0] e);
        checked++;
        if (avs_readdata !== e) begin
            miscompares++;
            $display("wrong value readdata %h expected %h seen %h",
                     a, e, avs_readdata);
        end
    endtask

    // read data is taken at the edge where waitrequest is sampled low
    always @(posedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            compare_read(adr_q.pop_front(), exp_q.pop_front());
        end
    end

    task automatic bus_op(input logic rd, input logic [5:0] a,
                          input logic [31:0] d);
        int n;
        n = 0;
        if (rd) begin
            exp_q.push_back(d);
            adr_q.push_back(a);
        end
        avs_address <= a;
        avs_writedata <= rd ? 32'h0 : d;
        avs_read <= rd;
        avs_write <= !rd;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 100) fail_wait();
        // one idle edge so the next request is a fresh rise
        @(posedge core_clk);
    endtask

    task automatic wait_done(input logic full);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while ((full ? corr_start : conv_done) !== 1'b1 && n < 2000);
        if (n >= 2000) fail_wait();
    endtask

    task automatic check_decode(input logic [15:0] c);
        logic [4:0] cb;
        logic [2:0] fb;
        cb = 5'h0A + {2'h0, c[7:6], 1'b0};
        fb = (c[9:8] == 2'h0) ? 3'h0 : {c[9:8], 1'b1};
        bus_op(1'b1, `BMS_ADDR_DECODED,
               {19'h0, cb + {2'h0, fb} - 5'h01, fb, cb});
    endtask

    task automatic read_raws();
        for (int k = 0; k < 3; k++) begin
            bus_op(1'b1, 6'(`BMS_ADDR_RAW_BRIDGE + 4 * k),
                   {14'h0, raw[k]});
        end
    endtask

    initial begin
        logic [15:0] cfg;
        void'($urandom(6));
        nvm_config <= 16'($urandom) & 16'h1FFF;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        repeat (3) @(posedge core_clk);
        bus_op(1'b1, `BMS_ADDR_CONFIG, {16'h0, nvm_config});
        check_decode(nvm_config);
        latency <= 8'($urandom_range(31));
        base <= 18'($urandom);
        bus_op(1'b0, `BMS_ADDR_CONTROL, 32'h1);
        // lands during wake, so it must be dropped
        bus_op(1'b0, `BMS_ADDR_CONFIG, {16'h0, nvm_config ^ 16'h1FFF});
        wait_done(1'b1);
        for (int k = 0; k < 3; k++) raw[k] = base + 18'(k);
        read_raws();
        bus_op(1'b1, `BMS_ADDR_CONFIG, {16'h0, nvm_config});
        bus_op(1'b1, `BMS_ADDR_STATUS, 32'h0000000D);
        for (int i = 0; i < 16; i++) begin
            cfg = {3'h0, 3'($urandom), i[3:2], i[1:0], i[0], i[2:0], i[1:0]};
            bus_op(1'b0, `BMS_ADDR_CONFIG, {16'h0, cfg});
            bus_op(1'b1, `BMS_ADDR_CONFIG, {16'h0, cfg});
            check_decode(cfg);
        end
        bus_op(1'b0, 6'h3C, $urandom);
        bus_op(1'b1, 6'h3C, 32'h0);
        bus_op(1'b0, `BMS_ADDR_CONTROL, 32'h3);
        repeat (WAKE + 5) @(posedge core_clk);
        for (int c = 3; c >= 0; c--) begin
            latency <= 8'($urandom_range(31));
            base <= 18'($urandom);
            bus_op(1'b0, `BMS_ADDR_CONTROL, 32'(c * 4 + 3));
            wait_done(c == 0);
            for (int k = 0; k < 3; k++) begin
                if (c == 0 || c == k + 1) raw[k] = base + 18'(k);
            end
            read_raws();
        end
        complete_run();
    end
endmodule
